// ==== rtl/ifd_decoder.sv ====
// Holds the instruction field decoder: single-word views and two-word pairing.
// Assumes program memory presents one word per cycle with a valid strobe.
`include "ifd_params.svh"

module ifd_decoder #(
  parameter logic [3:0] MOVE_OP = `IFD_MOVE_OP_DEF,
  parameter logic [7:0] CALL_OP = `IFD_CALL_OP_DEF,
  parameter logic [7:0] JUMP_OP = `IFD_JUMP_OP_DEF
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic word_valid_in,
  input wire logic [15:0] word_in,
  output logic dec_valid_out,
  output logic [5:0] opcode_out,
  output logic working_dest_out,
  output logic file_dest_out,
  output logic access_bank_out,
  output logic bank_from_select_out,
  output logic [7:0] file_addr_out,
  output logic [2:0] bit_pos_out,
  output logic [7:0] lit_opcode_out,
  output logic [7:0] literal_out,
  output logic move_done_out,
  output logic [11:0] move_src_out,
  output logic [11:0] move_dst_out,
  output logic long_done_out,
  output logic [7:0] long_op_out,
  output logic [19:0] target_out,
  output logic nop_out,
  output logic orphan_out
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    ifd_pkg::ifd_phase_e phase;
    logic dec_valid;
    logic [5:0] opcode;
    logic working_dest;
    logic access_bank;
    logic [7:0] file_addr;
    logic [2:0] bit_pos;
    logic [7:0] lit_opcode;
    logic [7:0] literal;
    logic move_done;
    logic [11:0] move_src;
    logic [11:0] move_dst;
    logic long_done;
    logic [7:0] long_op;
    logic [19:0] target;
    logic nop;
    logic orphan;
  } ifd_state_s;

  ifd_state_s st_q;
  ifd_state_s st_d;
  ifd_fields_if f ();

  assign f.word = word_in;

  ifd_field_split u_split (
    .f(f)
  );

  // A continuation word is recognised only by its upper four bits.
  function automatic logic ifd_is_cont(input logic [3:0] top4);
    ifd_is_cont = (top4 == `IFD_CONT_MARK);
  endfunction : ifd_is_cont

  // ********************************
  // Next state
  // ********************************
  logic waiting;
  logic cont;
  logic fresh;

  always_comb
  begin
    st_d = st_q;
    st_d.dec_valid = 1'b0;
    st_d.move_done = 1'b0;
    st_d.long_done = 1'b0;
    st_d.nop = 1'b0;
    st_d.orphan = 1'b0;
    waiting = (st_q.phase != ifd_pkg::IFD_IDLE);
    cont = ifd_is_cont(f.top4);
    fresh = word_valid_in && !(waiting && cont);
    if (word_valid_in && waiting)
    begin
      if (cont)
      begin
        st_d.phase = ifd_pkg::IFD_IDLE;
        unique case (st_q.phase)
          ifd_pkg::IFD_WAIT_MOVE:
          begin
            st_d.move_dst = f.addr12;
            st_d.move_done = 1'b1;
          end
          ifd_pkg::IFD_WAIT_LONG:
          begin
            st_d.target = {f.addr12, st_q.target[`IFD_FILE_HI:`IFD_FILE_LO]};
            st_d.long_done = 1'b1;
          end
          default:
          begin
            st_d.phase = ifd_pkg::IFD_IDLE;
          end
        endcase
      end
      else
      begin
        // A broken pair is reported and the new word decodes afresh.
        st_d.orphan = 1'b1;
        st_d.phase = ifd_pkg::IFD_IDLE;
      end
    end
    if (fresh)
    begin
      if (cont)
      begin
        st_d.nop = 1'b1;
      end
      else if (f.top4 == MOVE_OP)
      begin
        st_d.move_src = f.addr12;
        st_d.phase = ifd_pkg::IFD_WAIT_MOVE;
      end
      else if ((f.op8 == CALL_OP) || (f.op8 == JUMP_OP))
      begin
        st_d.long_op = f.op8;
        st_d.target = {12'h000, f.lit8};
        st_d.phase = ifd_pkg::IFD_WAIT_LONG;
      end
      else
      begin
        // All single-word views are offered; the pipeline picks by opcode.
        st_d.dec_valid = 1'b1;
        st_d.opcode = f.op6;
        st_d.working_dest = (f.dest == `IFD_DEST_WORKING);
        st_d.access_bank = (f.bank == `IFD_BANK_ACCESS);
        st_d.file_addr = f.file8;
        st_d.bit_pos = f.bitpos;
        st_d.lit_opcode = f.op8;
        st_d.literal = f.lit8;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign dec_valid_out = st_q.dec_valid;
  assign opcode_out = st_q.opcode;
  assign working_dest_out = st_q.working_dest;
  assign file_dest_out = st_q.dec_valid ? !st_q.working_dest : 1'b0;
  assign access_bank_out = st_q.access_bank;
  assign bank_from_select_out = st_q.dec_valid ? !st_q.access_bank : 1'b0;
  assign file_addr_out = st_q.file_addr;
  assign bit_pos_out = st_q.bit_pos;
  assign lit_opcode_out = st_q.lit_opcode;
  assign literal_out = st_q.literal;
  assign move_done_out = st_q.move_done;
  assign move_src_out = st_q.move_src;
  assign move_dst_out = st_q.move_dst;
  assign long_done_out = st_q.long_done;
  assign long_op_out = st_q.long_op;
  assign target_out = st_q.target;
  assign nop_out = st_q.nop;
  assign orphan_out = st_q.orphan;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_byte_fields: assert property (dec_valid_out |-> opcode_out == $past(word_in[15:10])
    && file_addr_out == $past(word_in[7:0]))
    else $error("Byte view fields do not match the word.");
  a_dest_select: assert property (dec_valid_out |->
    (working_dest_out == !$past(word_in[9])) && (file_dest_out == $past(word_in[9])))
    else $error("Destination select decoded wrongly.");
  a_bank_select: assert property (dec_valid_out |->
    access_bank_out != bank_from_select_out && access_bank_out == !$past(word_in[8]))
    else $error("Bank access select decoded wrongly.");
  a_file_addr8: assert property (dec_valid_out |-> $past(word_valid_in)
    && file_addr_out == $past(word_in[7:0]))
    else $error("File address is not bits seven to zero.");
  a_move_pair: assert property ((word_valid_in && !waiting && word_in[15:12] == MOVE_OP)
    ##1 (word_valid_in && word_in[15:12] == `IFD_CONT_MARK) |=> move_done_out)
    else $error("Two-word move did not complete.");
  a_move_addrs: assert property (move_done_out |-> move_dst_out == $past(word_in[11:0])
    && $past(st_q.phase) == ifd_pkg::IFD_WAIT_MOVE && !dec_valid_out)
    else $error("Move destination address wrong.");
  a_bit_fields: assert property (dec_valid_out |-> bit_pos_out == $past(word_in[11:9]))
    else $error("Bit position field wrong.");
  a_literal: assert property (dec_valid_out |-> lit_opcode_out == $past(word_in[15:8])
    && literal_out == $past(word_in[7:0]))
    else $error("Literal view fields wrong.");
  a_long_target: assert property (long_done_out |-> target_out[19:8] == $past(word_in[11:0])
    && target_out[7:0] == $past(st_q.target[7:0]))
    else $error("Long transfer target assembled wrongly.");
  a_lone_nop: assert property ((word_valid_in && !waiting && word_in[15:12] == `IFD_CONT_MARK)
    |=> nop_out && !dec_valid_out && !move_done_out && !long_done_out)
    else $error("Lone continuation word not a no-operation.");

  c_single: cover property (dec_valid_out);
  c_move: cover property (move_done_out);
  c_long: cover property (long_done_out);
  c_nop: cover property (nop_out);
  c_orphan: cover property (orphan_out ##1 dec_valid_out);

endmodule : ifd_decoder

// ==== rtl/ifd_params.svh ====
// Holds the field positions and fixed codes of the 16-bit instruction word.
// Assumes it is included by bare name from the decoder package and modules.
`ifndef IFD_PARAMS_SVH
`define IFD_PARAMS_SVH

// ********************************
// Field positions
// ********************************
`define IFD_OP6_HI 15
`define IFD_OP6_LO 10
`define IFD_DEST_BIT 9
`define IFD_BANK_BIT 8
`define IFD_FILE_HI 7
`define IFD_FILE_LO 0
`define IFD_BITPOS_HI 11
`define IFD_BITPOS_LO 9
`define IFD_OP8_HI 15
`define IFD_OP8_LO 8
`define IFD_TOP4_HI 15
`define IFD_TOP4_LO 12
`define IFD_ADDR12_HI 11
`define IFD_ADDR12_LO 0

// ********************************
// Fixed codes
// ********************************
`define IFD_CONT_MARK 4'hF
`define IFD_MOVE_OP_DEF 4'hC
`define IFD_CALL_OP_DEF 8'hEC
`define IFD_JUMP_OP_DEF 8'hEF
`define IFD_DEST_WORKING 1'h0
`define IFD_BANK_ACCESS 1'h0

`endif

// ==== rtl/ifd_pkg.sv ====
// Holds the types shared by the instruction field decoder modules.
// Assumes nothing beyond the parameter header.
`include "ifd_params.svh"

package ifd_pkg;

  typedef logic [15:0] ifd_word_t;

  typedef enum logic [1:0] {
    IFD_IDLE,
    IFD_WAIT_MOVE,
    IFD_WAIT_LONG
  } ifd_phase_e;

endpackage : ifd_pkg

// ==== rtl/ifd_fields_if.sv ====
// Carries one instruction word and its extracted field views.
// Assumes the splitter drives the fields and the decoder only reads them.
interface ifd_fields_if;
  ifd_pkg::ifd_word_t word;
  logic [5:0] op6;
  logic dest;
  logic bank;
  logic [7:0] file8;
  logic [2:0] bitpos;
  logic [7:0] op8;
  logic [7:0] lit8;
  logic [3:0] top4;
  logic [11:0] addr12;

  modport split (input word, output op6, dest, bank, file8, bitpos, op8, lit8, top4, addr12);
  modport user (output word, input op6, dest, bank, file8, bitpos, op8, lit8, top4, addr12);
endinterface : ifd_fields_if

// ==== rtl/ifd_field_split.sv ====
// Holds the combinational splitter that cuts a word into every field view.
// Assumes the caller picks the view that matches the instruction class.
`include "ifd_params.svh"

module ifd_field_split (
  ifd_fields_if.split f
);

  // ********************************
  // Field views
  // ********************************
  assign f.op6 = f.word[`IFD_OP6_HI:`IFD_OP6_LO];
  assign f.dest = f.word[`IFD_DEST_BIT];
  assign f.bank = f.word[`IFD_BANK_BIT];
  assign f.file8 = f.word[`IFD_FILE_HI:`IFD_FILE_LO];
  assign f.bitpos = f.word[`IFD_BITPOS_HI:`IFD_BITPOS_LO];
  assign f.op8 = f.word[`IFD_OP8_HI:`IFD_OP8_LO];
  assign f.lit8 = f.word[`IFD_FILE_HI:`IFD_FILE_LO];
  assign f.top4 = f.word[`IFD_TOP4_HI:`IFD_TOP4_LO];
  assign f.addr12 = f.word[`IFD_ADDR12_HI:`IFD_ADDR12_LO];

endmodule : ifd_field_split

// ==== tb/ifd_prog_mem.sv ====
// Holds a program memory model that hands one instruction word per cycle.
// Assumes the bench asks for a word just after a rising edge of the clock.
module ifd_prog_mem (
  input wire logic sys_clk_in,
  input wire logic fetch_in,
  input wire logic [15:0] next_word_in,
  output logic word_valid_out,
  output logic [15:0] word_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    word_valid_out = 1'h0;
    word_out = 16'h0000;
  end

  // Between fetches the valid strobe drops and the bus inverts every bit of its value on each falling edge, so a stale value never decodes.
  always @(negedge sys_clk_in)
  begin
    word_valid_out <= fetch_in;
    word_out <= fetch_in ? next_word_in : ~word_out;
  end
endmodule : ifd_prog_mem

// ==== tb/tb.sv ====
// Holds the self-checking bench of the instruction field decoder.
// Assumes the decoder answers on the same rising edge that takes a word, half a cycle after the memory presents it.
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk_in = 1'h0;
  logic nrst_in = 1'h0;
  logic fetch = 1'h0;
  logic [15:0] nxt = 16'h0000;
  logic wv;
  logic [15:0] w;
  logic dv, wd, fd, ab, bs, md, ld, nop, orph;
  logic [5:0] opc;
  logic [7:0] fa, lop, lit, lgop;
  logic [2:0] bp;
  logic [11:0] msrc, mdst;
  logic [19:0] tgt;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;

  initial
  begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  ifd_prog_mem mem (.sys_clk_in(sys_clk_in), .fetch_in(fetch), .next_word_in(nxt),
    .word_valid_out(wv), .word_out(w));

  ifd_decoder dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .word_valid_in(wv),
    .word_in(w), .dec_valid_out(dv), .opcode_out(opc), .working_dest_out(wd),
    .file_dest_out(fd), .access_bank_out(ab), .bank_from_select_out(bs),
    .file_addr_out(fa), .bit_pos_out(bp), .lit_opcode_out(lop), .literal_out(lit),
    .move_done_out(md), .move_src_out(msrc), .move_dst_out(mdst), .long_done_out(ld),
    .long_op_out(lgop), .target_out(tgt), .nop_out(nop), .orphan_out(orph));

  // ********************************
  // Shared tasks
  // ********************************
  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Fetch stays raised after a word, so back-to-back words never drop and raise it in one step.
  task automatic put(input logic [15:0] word);
    fetch = 1'h1;
    nxt = word;
    @(negedge sys_clk_in);
    @(posedge sys_clk_in);
    #1;
  endtask : put

  task automatic idle();
    fetch = 1'h0;
    @(negedge sys_clk_in);
    @(posedge sys_clk_in);
    #1;
  endtask : idle

  // ********************************
  // Scenarios
  // ********************************
  task automatic single(input logic [15:0] x);
    put(x);
    chk("dec_valid", 20'h1, dv);
    chk("opcode", x[15:10], opc);
    chk("working_dest", !x[9], wd);
    chk("file_dest", x[9], fd);
    chk("access_bank", !x[8], ab);
    chk("bank_select", x[8], bs);
    chk("file_addr", x[7:0], fa);
    chk("bit_pos", x[11:9], bp);
    chk("lit_opcode", x[15:8], lop);
    chk("literal", x[7:0], lit);
    idle();
    chk("dec_valid_fall", 20'h0, dv);
  endtask : single

  task automatic move_pair();
    put(16'hC123);
    chk("move_first", 20'h0, {md, dv});
    idle();
    idle();
    put(16'hF456);
    chk("move_done", 20'h1, md);
    chk("move_src", 20'h123, msrc);
    chk("move_dst", 20'h456, mdst);
    chk("move_no_nop", 20'h0, {nop, dv});
    put(16'hCABC);
    chk("move_b2b_first", 20'h0, md);
    put(16'hFDEF);
    chk("move_b2b_done", 20'h1, md);
    chk("move_b2b_src", 20'hABC, msrc);
    chk("move_b2b_dst", 20'hDEF, mdst);
  endtask : move_pair

  task automatic long_pairs();
    put(16'hEC34);
    put(16'hF012);
    chk("call_done", 20'h1, ld);
    chk("call_target", 20'h01234, tgt);
    chk("call_op", 20'hEC, lgop);
    put(16'hEF9A);
    chk("jump_first", 20'h0, ld);
    put(16'hFBCD);
    chk("jump_done", 20'h1, ld);
    chk("jump_target", 20'hBCD9A, tgt);
    chk("jump_op", 20'hEF, lgop);
  endtask : long_pairs

  task automatic lone_cont();
    put(16'hF000);
    chk("nop", 20'h1, nop);
    chk("nop_no_decode", 20'h0, {dv, md, ld});
    idle();
    chk("nop_fall", 20'h0, nop);
  endtask : lone_cont

  // A reset in mid-pair must drop the waiting first word.
  task automatic reset_mid();
    put(16'hC111);
    idle();
    @(negedge sys_clk_in);
    nrst_in = 1'h0;
    repeat (2) @(negedge sys_clk_in);
    chk("mid_reset_outputs", 20'h0, {md, dv, nop, msrc});
    nrst_in = 1'h1;
    @(posedge sys_clk_in);
    #1;
    chk("mid_reset_first_edge", 20'h0, {md, nop, dv});
    put(16'hF0F0);
    chk("mid_reset_nop", 20'h1, nop);
    chk("mid_reset_no_move", 20'h0, md);
    idle();
  endtask : reset_mid

  task automatic broken_pair();
    put(16'hC7AB);
    put(16'h2A55);
    chk("orphan", 20'h1, orph);
    chk("orphan_decode", 20'h1, dv);
    chk("orphan_addr", 20'h55, fa);
    chk("orphan_move", 20'h0, md);
  endtask : broken_pair

  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (12) @(negedge sys_clk_in);
    chk("reset_outputs", 20'h0, {dv, md, ld, nop, orph, fa});
    nrst_in = 1'h1;
    @(posedge sys_clk_in);
    #1;
    single(16'h2A55);
    single(16'h1181);
    single(16'h8E0F);
    single(16'h0FFE);
    single(16'h0CEE);
    move_pair();
    long_pairs();
    lone_cont();
    reset_mid();
    broken_pair();
    tally_and_finish();
  end
endmodule : tb
